// ---- src/pas_pkg.sv ----
// package: register map, field layout, timing and carrier types of the config bank
package pas_pkg;
	// ---------------------------------------------------------------
	// register offsets, reset values, writable masks
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_SLEEP   = 8'h02;
	localparam logic [7:0] OFS_SHDN    = 8'h05;
	localparam logic [7:0] OFS_FMT     = 8'h07;
	localparam logic [7:0] RST_SLEEP   = 8'h00;
	localparam logic [7:0] RST_SHDN    = 8'h05;
	localparam logic [7:0] RST_FMT     = 8'h30;
	localparam logic [7:0] WMASK_SLEEP = 8'hFD;
	localparam logic [7:0] WMASK_SHDN  = 8'h3F;
	localparam logic [7:0] WMASK_FMT   = 8'hFF;
	localparam logic [6:0] BCAST_ADDR  = 7'h4C;

	// ---------------------------------------------------------------
	// field positions (low bit of each field)
	// ---------------------------------------------------------------
	localparam int BIT_RAIL  = 7;
	localparam int BIT_REFQ  = 3;
	localparam int BIT_BCAST = 2;
	localparam int BIT_WAKE  = 0;
	localparam int BIT_INCAP = 4;
	localparam int BIT_SHDNB = 2;
	localparam int BIT_KA    = 0;

	// ---------------------------------------------------------------
	// timing, charge and keep-alive times in microseconds
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned CLK_MHZ       = 1000 / CLK_PERIOD_NS;
	localparam int unsigned REF_CHG_US [4] = '{3500, 10000, 50000, 100000};
	localparam int unsigned INCAP_US   [4] = '{2500, 12500, 25000, 50000};
	localparam int unsigned KEEP_US    [4] = '{30000, 25000, 10000, 5000};

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_TDM  = 2'b00,
		FMT_I2S  = 2'b01,
		FMT_LJ   = 2'b10,
		FMT_RSVD = 2'b11
	} pas_fmt_t;

	typedef enum logic [1:0] {
		SHDN_NOW   = 2'b00,
		SHDN_TIMED = 2'b01,
		SHDN_CLEAN = 2'b10,
		SHDN_RSVD  = 2'b11
	} pas_shdn_t;

	typedef enum logic [2:0] {
		I_IDLE  = 3'b000,
		I_ADDR  = 3'b001,
		I_AACK  = 3'b010,
		I_PTR   = 3'b011,
		I_WDATA = 3'b100,
		I_RXACK = 3'b101,
		I_RDATA = 3'b110,
		I_RACK  = 3'b111
	} pas_i2c_t;

	typedef struct packed {
		pas_fmt_t   fmt;
		logic [1:0] wlen;
		logic       fsPol;
		logic       bcPol;
		logic       txEdge;
		logic       txFill;
	} pas_audio_cfg_t;

	typedef struct packed {
		logic [31:0] pri0;
		logic [31:0] pri1;
		logic [31:0] sec0;
		logic [31:0] sec1;
	} pas_samples_t;
endpackage

// ---- src/pas_config_bank.sv ----
// power/sleep control and serial audio config bank behind a two-wire target
// Behaviour
// - rail select bit 7: 0 external analog rail, 1 internal regulator rail
// - reference quick-charge code picks 3.5, 10, 50 or 100 ms
// - broadcast enable makes the target also answer address 1001100
// - wake bit 0 low keeps device asleep; reset value keeps it asleep
// - input capacitor quick-charge code picks 2.5, 12.5, 25 or 50 ms
// - shutdown code 0 turns digital regulator off at once on shutdown
// - shutdown code 1 keeps regulator on until keep-alive timeout expires or clean shutdown ends
// - code 2 keeps regulator on until clean shutdown; code 3 never written
// - keep-alive code picks 30, 25, 10 or 5 ms
// - protocol code selects TDM, I2S or left-justified; code 3 unused
// - word length code picks 16, 20, 24 or 32 bits, reset 32
// - frame-sync and bit-clock polarity bits invert standard polarity
// - transmit-edge bit moves data launch half a bit clock earlier, or later when bit-clock polarity is inverted
// - fill bit: unused cycles drive zero, or release the data pin
`timescale 1ns/1ps

module pas_config_bank #(
	parameter logic [6:0]  DEV_ADDR   = 7'h4E,
	parameter int unsigned CYC_PER_US = pas_pkg::CLK_MHZ
) (
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire logic                  sclIn,
	input  wire logic                  sdaIn,
	output wire logic                  sdaOut,
	output wire logic                  sdaOe,
	input  wire logic                  shutdownPinN,
	input  wire logic                  cleanShutdownDone,
	input  wire pas_pkg::pas_samples_t samplesIn,
	input  wire logic                  bitClock,
	input  wire logic                  frameSyncIn,
	output wire logic                  dataPri,
	output wire logic                  dataPriOe,
	output wire logic                  dataSec,
	output wire logic                  dataSecOe,
	output wire logic                  analogRailInternal,
	output wire logic                  wakeActive,
	output wire logic                  refChargeActive,
	output wire logic                  inCapChargeActive,
	output wire logic                  regulatorOn
);
	if (CYC_PER_US == 0 || CYC_PER_US > 20000 || DEV_ADDR == pas_pkg::BCAST_ADDR) begin : g_chk
		$error("pas_config_bank: bad CYC_PER_US or DEV_ADDR");
	end

	function automatic logic [31:0] usToCycles(input int unsigned us);
		usToCycles = 32'(us * CYC_PER_US);
	endfunction

	function automatic logic [5:0] wlenBits(input logic [1:0] code);
		case (code)
			2'b00:   wlenBits = 6'h10;
			2'b01:   wlenBits = 6'h14;
			2'b10:   wlenBits = 6'h18;
			default: wlenBits = 6'h20;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// two-wire target
	// ---------------------------------------------------------------
	logic [7:0]        sleepReg_r, shdnReg_r, fmtReg_r;
	logic [1:0]        sclSync_r, sdaSync_r;
	logic              sclPrev_r, sdaPrev_r;
	pas_pkg::pas_i2c_t iState_r;
	logic [7:0]        shift_r, ptr_r, txByte_r;
	logic [3:0]        iCnt_r;
	logic              rw_r, sdaOe_r, wrEn, ackMatch;
	logic              sclRise, sclFall, startSeen, stopSeen;

	function automatic logic [7:0] regRead(input logic [7:0] ofs);
		case (ofs)
			pas_pkg::OFS_SLEEP: regRead = sleepReg_r;
			pas_pkg::OFS_SHDN:  regRead = shdnReg_r;
			pas_pkg::OFS_FMT:   regRead = fmtReg_r;
			default:            regRead = 8'h00;
		endcase
	endfunction

	// a process, not an assign, so a register write also refreshes it
	logic [7:0] rdByte;
	always_comb begin
		rdByte = regRead(ptr_r);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclSync_r <= 2'b11;
			sdaSync_r <= 2'b11;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end else begin
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			sclPrev_r <= sclSync_r[1];
			sdaPrev_r <= sdaSync_r[1];
		end
	end

	assign sclRise   = sclSync_r[1] & ~sclPrev_r;
	assign sclFall   = ~sclSync_r[1] & sclPrev_r;
	assign startSeen = sclSync_r[1] & sdaPrev_r & ~sdaSync_r[1];
	assign stopSeen  = sclSync_r[1] & ~sdaPrev_r & sdaSync_r[1];
	assign ackMatch  = shift_r[7:1] == DEV_ADDR ||
		(sleepReg_r[pas_pkg::BIT_BCAST] && shift_r[7:1] == pas_pkg::BCAST_ADDR);
	assign wrEn      = sclFall && iState_r == pas_pkg::I_WDATA && iCnt_r == 4'h8;
	assign sdaOut    = 1'b0;
	assign sdaOe     = sdaOe_r;

	always_ff @(posedge clk_sys) begin
		if (reset || stopSeen) begin
			iState_r <= pas_pkg::I_IDLE;
			sdaOe_r  <= 1'b0;
			iCnt_r   <= 4'h0;
		end else if (startSeen) begin
			iState_r <= pas_pkg::I_ADDR;
			sdaOe_r  <= 1'b0;
			iCnt_r   <= 4'h0;
		end else if (sclRise) begin
			if (iState_r inside {pas_pkg::I_ADDR, pas_pkg::I_PTR, pas_pkg::I_WDATA}) begin
				shift_r <= {shift_r[6:0], sdaSync_r[1]};
				iCnt_r  <= iCnt_r + 4'h1;
			end else if (iState_r == pas_pkg::I_RACK && sdaSync_r[1]) begin
				iState_r <= pas_pkg::I_IDLE;
			end
		end else if (sclFall) begin
			unique case (iState_r)
				pas_pkg::I_IDLE: ;
				pas_pkg::I_ADDR: if (iCnt_r == 4'h8) begin
					iState_r <= ackMatch ? pas_pkg::I_AACK : pas_pkg::I_IDLE;
					sdaOe_r  <= ackMatch;
					rw_r     <= shift_r[0];
				end
				pas_pkg::I_AACK, pas_pkg::I_RACK: begin
					iCnt_r <= 4'h0;
					if (rw_r) begin
						iState_r <= pas_pkg::I_RDATA;
						txByte_r <= {rdByte[6:0], 1'b0};
						sdaOe_r  <= ~rdByte[7];
						ptr_r    <= ptr_r + 8'h01;
						iCnt_r   <= 4'h1;
					end else begin
						iState_r <= pas_pkg::I_PTR;
						sdaOe_r  <= 1'b0;
					end
				end
				pas_pkg::I_PTR, pas_pkg::I_WDATA: if (iCnt_r == 4'h8) begin
					if (iState_r == pas_pkg::I_PTR) begin
						ptr_r <= shift_r;
					end else begin
						ptr_r <= ptr_r + 8'h01;
					end
					iState_r <= pas_pkg::I_RXACK;
					sdaOe_r  <= 1'b1;
				end
				pas_pkg::I_RXACK: begin
					iState_r <= pas_pkg::I_WDATA;
					sdaOe_r  <= 1'b0;
					iCnt_r   <= 4'h0;
				end
				pas_pkg::I_RDATA: begin
					if (iCnt_r == 4'h8) begin
						iState_r <= pas_pkg::I_RACK;
						sdaOe_r  <= 1'b0;
					end else begin
						sdaOe_r  <= ~txByte_r[7];
						txByte_r <= {txByte_r[6:0], 1'b0};
						iCnt_r   <= iCnt_r + 4'h1;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// register bank
	// ---------------------------------------------------------------
	// read-only reserved bits are masked; writable reserved bits keep
	// whatever software writes, which must be their reset value
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sleepReg_r <= pas_pkg::RST_SLEEP;
			shdnReg_r  <= pas_pkg::RST_SHDN;
			fmtReg_r   <= pas_pkg::RST_FMT;
		end else if (wrEn) begin
			unique case (ptr_r)
				pas_pkg::OFS_SLEEP: sleepReg_r <= shift_r & pas_pkg::WMASK_SLEEP;
				pas_pkg::OFS_SHDN:  shdnReg_r  <= shift_r & pas_pkg::WMASK_SHDN;
				pas_pkg::OFS_FMT:   fmtReg_r   <= shift_r & pas_pkg::WMASK_FMT;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// sleep, quick-charge and shutdown control
	// ---------------------------------------------------------------
	logic [1:0]         shdnSync_r;
	logic               shdnPrev_r, awakePrev_r, awake, awakeRise, shdnFall;
	logic               railInt_r, wake_r, regOn_r;
	logic [31:0]        kaCnt_r;
	logic [1:0]         chgActive_r;
	logic [31:0]        chgCnt_r [2];
	logic [31:0]        chgLoad [2];
	pas_pkg::pas_shdn_t shdnMode;

	assign shdnMode   = pas_pkg::pas_shdn_t'(shdnReg_r[pas_pkg::BIT_SHDNB +: 2]);
	assign awake      = sleepReg_r[pas_pkg::BIT_WAKE] & shdnSync_r[1];
	assign awakeRise  = awake & ~awakePrev_r;
	assign shdnFall   = shdnPrev_r & ~shdnSync_r[1];
	assign chgLoad[0] = usToCycles(pas_pkg::REF_CHG_US[sleepReg_r[pas_pkg::BIT_REFQ +: 2]]);
	assign chgLoad[1] = usToCycles(pas_pkg::INCAP_US[shdnReg_r[pas_pkg::BIT_INCAP +: 2]]);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			shdnSync_r  <= 2'b00;
			shdnPrev_r  <= 1'b0;
			awakePrev_r <= 1'b0;
			railInt_r   <= 1'b0;
			wake_r      <= 1'b0;
		end else begin
			shdnSync_r  <= {shdnSync_r[0], shutdownPinN};
			shdnPrev_r  <= shdnSync_r[1];
			awakePrev_r <= awake;
			railInt_r   <= sleepReg_r[pas_pkg::BIT_RAIL];
			wake_r      <= awake;
		end
	end

	// charge timers restart each time the device leaves sleep
	for (genvar i = 0; i < 2; i++) begin : g_chg
		always_ff @(posedge clk_sys) begin
			if (reset || !awake) begin
				chgCnt_r[i]    <= 32'h0000_0000;
				chgActive_r[i] <= 1'b0;
			end else if (awakeRise) begin
				chgCnt_r[i]    <= chgLoad[i];
				chgActive_r[i] <= 1'b1;
			end else if (chgCnt_r[i] != 32'h0000_0000) begin
				chgCnt_r[i]    <= chgCnt_r[i] - 32'h0000_0001;
				chgActive_r[i] <= chgCnt_r[i] != 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			kaCnt_r <= 32'h0000_0000;
		end else if (shdnFall) begin
			kaCnt_r <= usToCycles(pas_pkg::KEEP_US[shdnReg_r[pas_pkg::BIT_KA +: 2]]);
		end else if (kaCnt_r != 32'h0000_0000) begin
			kaCnt_r <= kaCnt_r - 32'h0000_0001;
		end
	end

	// reserved code 3 is handled like code 2, the safest choice
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			regOn_r <= 1'b0;
		end else if (shdnSync_r[1]) begin
			regOn_r <= 1'b1;
		end else begin
			unique case (shdnMode)
				pas_pkg::SHDN_NOW:   regOn_r <= 1'b0;
				pas_pkg::SHDN_TIMED: begin
					if (cleanShutdownDone || kaCnt_r == 32'h0000_0001) begin
						regOn_r <= 1'b0;
					end
				end
				pas_pkg::SHDN_CLEAN, pas_pkg::SHDN_RSVD: begin
					if (cleanShutdownDone) begin
						regOn_r <= 1'b0;
					end
				end
			endcase
		end
	end

	assign analogRailInternal = railInt_r;
	assign wakeActive         = wake_r;
	assign refChargeActive    = chgActive_r[0];
	assign inCapChargeActive  = chgActive_r[1];
	assign regulatorOn        = regOn_r;

	// ---------------------------------------------------------------
	// sample handshake, system side
	// ---------------------------------------------------------------
	logic [1:0]            reqSync_r;
	logic                  reqPrev_r, ackTgl_r, reqTgl_r;
	pas_pkg::pas_samples_t hold_r;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reqSync_r <= 2'b00;
			reqPrev_r <= 1'b0;
			ackTgl_r  <= 1'b0;
			hold_r    <= '0;
		end else begin
			reqSync_r <= {reqSync_r[0], reqTgl_r};
			reqPrev_r <= reqSync_r[1];
			if (reqSync_r[1] != reqPrev_r) begin
				hold_r   <= samplesIn;
				ackTgl_r <= ~ackTgl_r;
			end
		end
	end

	// ---------------------------------------------------------------
	// serial audio port, bit clock side
	// ---------------------------------------------------------------
	// frame sync is always sampled on the rising bit clock; polarity only
	// moves the data launch edge. settings should change while idle.
	logic [1:0]             rstL_r, ackSyncL_r;
	pas_pkg::pas_audio_cfg_t cfgS1_r, cfgL_r;
	logic                   ackPrevL_r, fsPrev_r, launchRise_r;
	logic [5:0]             idx_r, idxNxt, wl;
	logic [1:0]             slot_r, slotNxt;
	pas_pkg::pas_samples_t  word_r;
	logic                   fs, leftEvt, rightEvt, active;
	logic [1:0]             txBitR_r, txEnR_r, txBitF_r, txEnF_r;

	assign fs       = frameSyncIn ^ cfgL_r.fsPol;
	assign wl       = wlenBits(cfgL_r.wlen);
	assign leftEvt  = (cfgL_r.fmt == pas_pkg::FMT_I2S) ? (~fs & fsPrev_r) : (fs & ~fsPrev_r);
	assign rightEvt = (cfgL_r.fmt == pas_pkg::FMT_I2S) ? (fs & ~fsPrev_r) :
		(cfgL_r.fmt == pas_pkg::FMT_LJ) ? (~fs & fsPrev_r) : 1'b0;

	always_comb begin
		slotNxt = slot_r;
		idxNxt  = (idx_r == 6'h28) ? idx_r : idx_r + 6'h01;
		if (leftEvt || rightEvt) begin
			slotNxt = leftEvt ? 2'b00 : 2'b01;
			idxNxt  = (cfgL_r.fmt == pas_pkg::FMT_I2S) ? 6'h3F : 6'h00;
		end else if (cfgL_r.fmt == pas_pkg::FMT_TDM && slot_r == 2'b00 && idx_r == wl - 6'h01) begin
			slotNxt = 2'b01;
			idxNxt  = 6'h00;
		end
		active = slotNxt != 2'b10 && idxNxt < wl;
	end

	always_ff @(posedge bitClock) begin
		rstL_r     <= {rstL_r[0], reset};
		ackSyncL_r <= {ackSyncL_r[0], ackTgl_r};
		cfgS1_r    <= pas_pkg::pas_audio_cfg_t'(fmtReg_r);
		cfgL_r     <= cfgS1_r;
	end

	always_ff @(posedge bitClock) begin
		if (rstL_r[1]) begin
			fsPrev_r     <= 1'b0;
			ackPrevL_r   <= 1'b0;
			reqTgl_r     <= 1'b0;
			slot_r       <= 2'b10;
			idx_r        <= 6'h28;
			word_r       <= '0;
			txBitR_r     <= 2'b00;
			txEnR_r      <= 2'b00;
			launchRise_r <= 1'b0;
		end else begin
			fsPrev_r     <= fs;
			ackPrevL_r   <= ackSyncL_r[1];
			reqTgl_r     <= reqTgl_r ^ leftEvt;
			slot_r       <= slotNxt;
			idx_r        <= idxNxt;
			launchRise_r <= cfgL_r.bcPol ^ cfgL_r.txEdge;
			if (ackSyncL_r[1] != ackPrevL_r) begin
				word_r <= hold_r;
			end
			// same slot timing drives both pins
			txBitR_r[0] <= active & (slotNxt[0] ? word_r.pri1[~idxNxt[4:0]] : word_r.pri0[~idxNxt[4:0]]);
			txBitR_r[1] <= active & (slotNxt[0] ? word_r.sec1[~idxNxt[4:0]] : word_r.sec0[~idxNxt[4:0]]);
			txEnR_r     <= {2{active | ~cfgL_r.txFill}};
		end
	end

	always_ff @(negedge bitClock) begin
		if (rstL_r[1]) begin
			txBitF_r <= 2'b00;
			txEnF_r  <= 2'b00;
		end else begin
			txBitF_r <= txBitR_r;
			txEnF_r  <= txEnR_r;
		end
	end

	assign dataPri   = launchRise_r ? txBitR_r[0] : txBitF_r[0];
	assign dataPriOe = launchRise_r ? txEnR_r[0] : txEnF_r[0];
	assign dataSec   = launchRise_r ? txBitR_r[1] : txBitF_r[1];
	assign dataSecOe = launchRise_r ? txEnR_r[1] : txEnF_r[1];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_rail;
		@(posedge clk_sys) disable iff (reset) ##1 railInt_r == $past(sleepReg_r[7]);
	endproperty
	a_rail: assert property (p_rail) else $error("rail select not followed");

	property p_sleep;
		@(posedge clk_sys) disable iff (reset) !sleepReg_r[0] |=> !wake_r;
	endproperty
	a_sleep: assert property (p_sleep) else $error("device awake with wake bit low");

	property p_refLoad;
		@(posedge clk_sys) disable iff (reset) awakeRise |=> chgCnt_r[0] == $past(chgLoad[0]) && chgActive_r[0];
	endproperty
	a_refLoad: assert property (p_refLoad) else $error("reference charge not started");

	property p_capLoad;
		@(posedge clk_sys) disable iff (reset) awakeRise |=> chgCnt_r[1] == $past(chgLoad[1]);
	endproperty
	a_capLoad: assert property (p_capLoad) else $error("input charge not started");

	property p_shdnNow;
		@(posedge clk_sys) disable iff (reset) !shdnSync_r[1] && shdnMode == pas_pkg::SHDN_NOW |=> !regOn_r;
	endproperty
	a_shdnNow: assert property (p_shdnNow) else $error("regulator not off at once");

	property p_keepAlive;
		@(posedge clk_sys) disable iff (reset)
			shdnFall && shdnMode == pas_pkg::SHDN_TIMED && !cleanShutdownDone && $past(regOn_r)
			|=> regOn_r && kaCnt_r == usToCycles(pas_pkg::KEEP_US[$past(shdnReg_r[1:0])]);
	endproperty
	a_keepAlive: assert property (p_keepAlive) else $error("keep-alive not started");

	property p_timeout;
		@(posedge clk_sys) disable iff (reset)
			!shdnSync_r[1] && shdnMode == pas_pkg::SHDN_TIMED && kaCnt_r == 32'h0000_0001 |=> !regOn_r;
	endproperty
	a_timeout: assert property (p_timeout) else $error("regulator on past timeout");

	property p_clean;
		@(posedge clk_sys) disable iff (reset)
			!shdnSync_r[1] && shdnMode == pas_pkg::SHDN_CLEAN && !cleanShutdownDone && regOn_r |=> regOn_r;
	endproperty
	a_clean: assert property (p_clean) else $error("regulator off before clean end");

	property p_bcast;
		@(posedge clk_sys) disable iff (reset || startSeen || stopSeen)
			sclFall && iState_r == pas_pkg::I_ADDR && iCnt_r == 4'h8 && sleepReg_r[2]
			&& shift_r[7:1] == pas_pkg::BCAST_ADDR |=> sdaOe_r && iState_r == pas_pkg::I_AACK;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast address not acknowledged");

	property p_fill;
		@(posedge bitClock) disable iff (rstL_r[1]) !active && !cfgL_r.txFill |=> txEnR_r == 2'b11 && txBitR_r == 2'b00;
	endproperty
	a_fill: assert property (p_fill) else $error("unused cycle not driven low");

	property p_wlen;
		@(posedge bitClock) disable iff (rstL_r[1]) active |-> wl >= 6'h10 &&
			idxNxt < ((cfgL_r.wlen == 2'b11) ? 6'h20 : 6'h10 + {2'b00, cfgL_r.wlen, 2'b00});
	endproperty
	a_wlen: assert property (p_wlen) else $error("bit outside word length");

	c_wake:    cover property (@(posedge clk_sys) disable iff (reset) awakeRise ##1 chgActive_r[0]);
	c_timeout: cover property (@(posedge clk_sys) disable iff (reset) $fell(regOn_r) && kaCnt_r == 32'h0000_0000);
	c_write:   cover property (@(posedge clk_sys) disable iff (reset) wrEn && ptr_r == pas_pkg::OFS_FMT);
	c_slot:    cover property (@(posedge bitClock) disable iff (rstL_r[1]) leftEvt ##1 active [*8]);
endmodule

// ---- verif/pas_host_model.sv ----
// host audio processor model: bit clock, frame sync, capture of both data pins
`timescale 1ns/1ps

module pas_host_model (
	input  wire logic   run,
	input  wire logic   tdm,
	input  wire logic   startLvl,
	output logic        bitClock,
	output logic        frameSyncIn,
	input  wire logic   dataPri,
	input  wire logic   dataPriOe,
	input  wire logic   dataSec,
	input  wire logic   dataSecOe,
	output logic [63:0] snapRise,
	output logic [63:0] snapFall,
	output logic [63:0] snapSec,
	output logic [63:0] snapOe
);
	logic [63:0] riseP, fallP, riseS, oeP;
	int          bitPos = 63;
	// a released pin shows the inverse of its last sample, never a stale level
	wire logic   pinP = dataPriOe ? dataPri : !riseP[0];
	wire logic   pinS = dataSecOe ? dataSec : !riseS[0];

	// clock stands still low while idle; odd start offset keeps it out of phase
	initial begin
		bitClock = 1'b0;
		#7.1;
		forever begin
			#32;
			if (run || bitClock)
				bitClock = !bitClock;
		end
	end

	always @(negedge bitClock) begin
		frameSyncIn <= tdm ? ((bitPos == 63) ^ startLvl) : ((bitPos == 63 || bitPos < 31) ~^ startLvl);
		fallP <= {fallP[62:0], pinP};
	end

	always @(posedge bitClock) begin
		if (bitPos == 63) begin
			snapRise <= riseP;
			snapFall <= fallP;
			snapSec <= riseS;
			snapOe <= oeP;
		end
		bitPos <= (bitPos + 1) % 64;
		riseP <= {riseP[62:0], pinP};
		riseS <= {riseS[62:0], pinS};
		oeP <= {oeP[62:0], dataPriOe};
	end
endmodule

// ---- verif/test_power_and_audio_serial_config.sv ----
// bench: two-wire register access, power sequencing and serial framing checks
`timescale 1ns/1ps

module test_power_and_audio_serial_config;
	localparam logic [6:0] ADDR = 7'h4E;
	logic                  clk_sys, reset, sclIn, sdaDrv, shutdownPinN, cleanShutdownDone;
	logic                  run, tdm, startLvl, ack;
	logic [7:0]            rd;
	logic [7:0]            cfg [8] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h80, 8'h40, 8'h20, 8'h01};
	int                    s0 [8] = '{47, 47, 47, 47, 47, 46, 39, 47};
	int                    s1 [8] = '{31, 31, 31, 31, 15, 14, 15, 31};
	logic [7:0]            ofs [4] = '{8'h02, 8'h05, 8'h07, 8'h03};
	logic [7:0]            rv [4] = '{8'h00, 8'h05, 8'h30, 8'h00};
	logic [7:0]            shCfg [3] = '{8'h00, 8'h07, 8'h09};
	int                    lo [3] = '{0, 5000, 30000};
	int                    fails = 0, tests_run = 0, refCnt = 0, capCnt = 0, n, wl, d;
	pas_pkg::pas_samples_t smp;
	wire logic             sdaOut, sdaOe, bitClock, frameSyncIn, dataPri, dataPriOe, dataSec;
	wire logic             dataSecOe, railInt, wakeActive, refChg, capChg, regulatorOn;
	wire logic [63:0]      snapRise, snapFall, snapSec, snapOe;
	// open-drain line with pull-up
	wire logic             sdaIn = sdaDrv && !(sdaOe && !sdaOut);

	pas_config_bank #(.DEV_ADDR(ADDR), .CYC_PER_US(1)) i_pas_config_bank (
		.clk_sys(clk_sys), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .shutdownPinN(shutdownPinN), .cleanShutdownDone(cleanShutdownDone),
		.samplesIn(smp), .bitClock(bitClock), .frameSyncIn(frameSyncIn), .dataPri(dataPri),
		.dataPriOe(dataPriOe), .dataSec(dataSec), .dataSecOe(dataSecOe),
		.analogRailInternal(railInt), .wakeActive(wakeActive), .refChargeActive(refChg),
		.inCapChargeActive(capChg), .regulatorOn(regulatorOn));
	pas_host_model i_pas_host_model (
		.run(run), .tdm(tdm), .startLvl(startLvl), .bitClock(bitClock),
		.frameSyncIn(frameSyncIn), .dataPri(dataPri), .dataPriOe(dataPriOe), .dataSec(dataSec),
		.dataSecOe(dataSecOe), .snapRise(snapRise), .snapFall(snapFall), .snapSec(snapSec),
		.snapOe(snapOe));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = !clk_sys;
	end
	always @(negedge clk_sys) begin
		if (refChg === 1'b1)
			refCnt++;
		if (capChg === 1'b1)
			capCnt++;
	end

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic hold(input int c);
		repeat (c) @(negedge clk_sys);
	endtask
	task automatic checkVal(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic checkFlag(input logic got, input logic exp);
		checkVal({63'h0, got}, {63'h0, exp});
	endtask
	// only one pin moves per step, so no false start or stop is seen
	task automatic step(input logic c, input logic s);
		sclIn = c;
		sdaDrv = s;
		hold(4);
	endtask
	task automatic i2cStart;
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic i2cByte(input logic [7:0] b, output logic [7:0] q, output logic k);
		for (int i = 8; i >= 0; i--) begin
			step(1'b0, i > 0 ? b[i - 1] : 1'b1);
			step(1'b1, sclIn ? sdaDrv : sdaDrv);
			if (i > 0)
				q[i - 1] = sdaIn;
			else
				k = !sdaIn;
			step(1'b0, sdaDrv);
		end
	endtask
	task automatic access(input logic [6:0] a, input logic [7:0] p, input logic wr,
			input logic [7:0] dat, output logic [7:0] q, output logic ok);
		logic [7:0] t;
		logic       k1, k2, k3;
		i2cStart();
		i2cByte({a, 1'b0}, t, k1);
		i2cByte(p, t, k2);
		k3 = 1'b1;
		if (!wr) begin
			i2cStart();
			i2cByte({a, 1'b1}, t, k3);
		end
		i2cByte(wr ? dat : 8'hFF, q, ok);
		ok = k1 && k2 && k3 && (ok || !wr);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	task automatic doReset;
		reset = 1'b1;
		hold(4);
		repeat (3) @(posedge bitClock);
		hold(1);
		reset = 1'b0;
		hold(4);
	endtask
	function automatic logic [63:0] frame(input logic [31:0] a, b, input int sh);
		return ((64'(a) >> (32 - wl)) << (s0[d] + sh)) | ((64'(b) >> (32 - wl)) << (s1[d] + sh));
	endfunction
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#450000;
		fails++;
		test_done();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		{reset, sclIn, sdaDrv, shutdownPinN, run, tdm} = 6'b11_1111;
		{cleanShutdownDone, startLvl} = 2'b00;
		smp = '{32'hA5C3_1234, 32'h3C96_8421, 32'h8001_F00F, 32'h7FFE_0FF0};
		doReset();
		checkFlag(wakeActive, 1'b0);
		for (int i = 0; i < 4; i++) begin
			access(ADDR, ofs[i], 1'b0, 8'h00, rd, ack);
			checkVal(64'(rd), 64'(rv[i]));
		end
		access(ADDR, pas_pkg::OFS_SLEEP, 1'b1, 8'h85, rd, ack);
		checkFlag(ack, 1'b1);
		hold(4);
		checkFlag(railInt, 1'b1);
		checkFlag(wakeActive, 1'b1);
		hold(4000);
		checkVal(64'(refCnt), 64'd3500);
		checkVal(64'(capCnt), 64'd2500);
		access(7'b100_1100, pas_pkg::OFS_SLEEP, 1'b0, 8'h00, rd, ack);
		checkVal({ack, rd}, 64'h185);
		access(ADDR, pas_pkg::OFS_SLEEP, 1'b1, 8'h01, rd, ack);
		hold(4);
		checkFlag(railInt, 1'b0);
		access(7'b100_1100, pas_pkg::OFS_SLEEP, 1'b0, 8'h00, rd, ack);
		checkFlag(ack, 1'b0);
		for (d = 0; d < 8; d++) begin
			run = 1'b0;
			hold(40);
			access(ADDR, pas_pkg::OFS_FMT, 1'b1, cfg[d], rd, ack);
			tdm = cfg[d][7:6] == 2'b00;
			startLvl = cfg[d][3] ^ (cfg[d][7:6] == 2'b10);
			wl = cfg[d][5:4] == 2'b10 ? 24 : 16;
			run = 1'b1;
			repeat (260) @(posedge bitClock);
			hold(1);
			checkVal(snapOe, cfg[d][0] ? 64'h7FFF_FFFF_8000_0000 : 64'hFFFF_FFFF_FFFF_FFFF);
			if (!cfg[d][0]) begin
				checkVal(snapRise, frame(smp.pri0, smp.pri1, 0));
				checkVal(snapSec, frame(smp.sec0, smp.sec1, 0));
				checkVal(snapFall, frame(smp.pri0, smp.pri1, cfg[d][2] ^ cfg[d][1]));
			end
		end
		for (int i = 0; i < 3; i++) begin
			doReset();
			access(ADDR, pas_pkg::OFS_SHDN, 1'b1, shCfg[i], rd, ack);
			hold(10);
			checkFlag(regulatorOn, 1'b1);
			shutdownPinN = 1'b0;
			n = 0;
			while (regulatorOn === 1'b1 && n < 40000) begin
				hold(1);
				n++;
				cleanShutdownDone = i == 2 && n >= 30000;
			end
			checkFlag(n >= lo[i] && n <= lo[i] + 4, 1'b1);
			{shutdownPinN, cleanShutdownDone} = 2'b10;
		end
		test_done();
	end
endmodule
